/* File: verilog/tcr_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tcr_top #(
	parameter int CONV_CYCLES = tcr_pkg::CONV_CYCLES_12,
	parameter logic [63:0] ID_CODE = 64'h0123_4567_89ab_cd01 // Arbitrary value
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// Command strobe from the bus layer
	input wire logic CMD_VALID_I,
	input wire logic [7:0] CMD_CODE_I,
	// Completion polling
	input wire logic RD_SLOT_I,
	output logic RD_VALID_O,
	output logic RD_BIT_O,
	// Scratchpad access
	input wire logic SP_RD_I,
	input wire logic [3:0] SP_RD_ADDR_I,
	output logic SP_RD_VALID_O,
	output logic [7:0] SP_RD_DATA_O,
	input wire logic SP_WR_I,
	input wire tcr_pkg::tcr_sp_wr_t SP_WR_DATA_I,
	// Nonvolatile store
	input wire logic NV_VALID_I,
	input wire tcr_pkg::tcr_nv_t NV_IMAGE_I,
	input wire logic NV_STORE_I,
	output logic NV_WR_O,
	output tcr_pkg::tcr_nv_t NV_WR_DATA_O,
	// Sensor front end
	input wire logic [11:0] SENSE_I,
	// Status
	input wire logic SUPPLY_PIN_I,
	output logic EXT_POWERED_O,
	output logic CONV_BUSY_O,
	output logic ALARM_O,
	output logic [15:0] TEMP_RESULT_O,
	output logic [63:0] ID_CODE_O
);
	import tcr_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [CNT_W-1:0] conv_limit(input logic [1:0] res);
		logic [CNT_W-1:0] full;
		full = CNT_W'(CONV_CYCLES);
		// Each step down in resolution halves the conversion time
		conv_limit = full >> (RES_12 - res);
	endfunction : conv_limit

	function automatic logic [15:0] fmt_result(input logic [11:0] raw, input logic [1:0] res);
		logic [11:0] kept;
		logic [11:0] mask;
		mask = 12'hfff << (RES_12 - res);
		// Unused low bits are forced to zero so reads stay deterministic
		kept = raw & mask;
		fmt_result = {{4{kept[SIGN_BIT]}}, kept};
	endfunction : fmt_result

	function automatic logic s_gt(input logic [7:0] a, input logic [7:0] b);
		s_gt = $signed(a) > $signed(b);
	endfunction : s_gt

	// ****************************************
	// Supply sense synchroniser
	// ****************************************
	logic sup_meta_reg, sup_meta_next;
	logic sup_sync_reg, sup_sync_next;
	logic ext_pwr_reg, ext_pwr_next;

	always_comb begin
		sup_meta_next = SUPPLY_PIN_I;
		sup_sync_next = sup_meta_reg;
		ext_pwr_next = sup_sync_reg;
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			sup_meta_reg <= 1'b0;
			sup_sync_reg <= 1'b0;
			ext_pwr_reg <= 1'b0;
		end else begin
			sup_meta_reg <= sup_meta_next;
			sup_sync_reg <= sup_sync_next;
			ext_pwr_reg <= ext_pwr_next;
		end
	end

	// ****************************************
	// Settings and nonvolatile image
	// ****************************************
	logic loaded_reg, loaded_next;
	tcr_nv_t set_reg, set_next;
	logic nv_wr_reg, nv_wr_next;
	tcr_nv_t nv_data_reg, nv_data_next;

	always_comb begin
		loaded_next = 1'b1;
		set_next = set_reg;
		nv_wr_next = NV_STORE_I;
		nv_data_next = NV_STORE_I ? set_reg : nv_data_reg;
		// Stored image loads once, in the first cycle after reset release
		if (!loaded_reg) begin
			if (NV_VALID_I) begin
				set_next = NV_IMAGE_I;
			end
		end else if (SP_WR_I) begin
			unique case (SP_WR_DATA_I.addr)
				SP_ALARM_HI: set_next.alarm_hi = SP_WR_DATA_I.data;
				SP_ALARM_LO: set_next.alarm_lo = SP_WR_DATA_I.data;
				SP_CONFIG: set_next.config_byte = SP_WR_DATA_I.data;
				default: set_next = set_reg;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			loaded_reg <= 1'b0;
			set_reg <= '{alarm_hi: ALARM_HI_RESET, alarm_lo: ALARM_LO_RESET,
				config_byte: CONFIG_RESET};
			nv_wr_reg <= 1'b0;
			nv_data_reg <= '0;
		end else begin
			loaded_reg <= loaded_next;
			set_reg <= set_next;
			nv_wr_reg <= nv_wr_next;
			nv_data_reg <= nv_data_next;
		end
	end

	// ****************************************
	// Conversion control
	// ****************************************
	tcr_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [CNT_W-1:0] lim_reg, lim_next;
	logic [1:0] res_reg, res_next;
	logic [15:0] temp_reg, temp_next;
	logic alarm_reg, alarm_next;
	logic [15:0] result;
	logic [1:0] res_now;

	always_comb begin
		res_now = set_reg.config_byte[CFG_RES_LSB +: 2];
		result = fmt_result(SENSE_I, res_reg);
		state_next = state_reg;
		cnt_next = cnt_reg;
		lim_next = lim_reg;
		res_next = res_reg;
		temp_next = temp_reg;
		alarm_next = alarm_reg;
		unique case (state_reg)
			ST_IDLE: begin
				// A start during a conversion is ignored; the first one runs on
				if (CMD_VALID_I && CMD_CODE_I == CMD_CONVERT) begin
					state_next = ST_CONV;
					cnt_next = '0;
					res_next = res_now;
					lim_next = conv_limit(res_now);
				end
			end
			ST_CONV: begin
				cnt_next = cnt_reg + CNT_W'(1);
				if (cnt_reg >= lim_reg - CNT_W'(1)) begin
					// Whole word in one edge, so no half-old read is possible
					temp_next = result;
					alarm_next = s_gt(result[SIGN_BIT:CMP_LSB], set_reg.alarm_hi)
						|| s_gt(set_reg.alarm_lo, result[SIGN_BIT:CMP_LSB]);
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			lim_reg <= '0;
			res_reg <= RES_12;
			temp_reg <= TEMP_RESET;
			alarm_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			lim_reg <= lim_next;
			res_reg <= res_next;
			temp_reg <= temp_next;
			alarm_reg <= alarm_next;
		end
	end

	// ****************************************
	// Read slots and scratchpad reads
	// ****************************************
	logic rd_valid_reg, rd_valid_next;
	logic rd_bit_reg, rd_bit_next;
	logic sp_valid_reg, sp_valid_next;
	logic [7:0] sp_data_reg, sp_data_next;
	logic [63:0] id_reg;

	always_comb begin
		rd_valid_next = RD_SLOT_I;
		rd_bit_next = RD_SLOT_I ? (state_reg == ST_IDLE) : rd_bit_reg;
		sp_valid_next = SP_RD_I;
		sp_data_next = sp_data_reg;
		if (SP_RD_I) begin
			if (SP_RD_ADDR_I == SP_TEMP_LO) begin
				sp_data_next = temp_reg[7:0];
			end else if (SP_RD_ADDR_I == SP_TEMP_HI) begin
				sp_data_next = temp_reg[15:8];
			end else if (SP_RD_ADDR_I == SP_ALARM_HI) begin
				sp_data_next = set_reg.alarm_hi;
			end else if (SP_RD_ADDR_I == SP_ALARM_LO) begin
				sp_data_next = set_reg.alarm_lo;
			end else if (SP_RD_ADDR_I == SP_CONFIG) begin
				sp_data_next = set_reg.config_byte;
			end else if (SP_RD_ADDR_I >= SP_RSVD_FIRST && SP_RD_ADDR_I <= SP_RSVD_LAST) begin
				sp_data_next = SP_RSVD_VALUE;
			end else if (SP_RD_ADDR_I == SP_CHECK) begin
				sp_data_next = SP_CHECK_VALUE;
			end else begin
				sp_data_next = SP_UNMAPPED_VALUE;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rd_valid_reg <= 1'b0;
			rd_bit_reg <= 1'b1;
			sp_valid_reg <= 1'b0;
			sp_data_reg <= '0;
			id_reg <= '0;
		end else begin
			rd_valid_reg <= rd_valid_next;
			rd_bit_reg <= rd_bit_next;
			sp_valid_reg <= sp_valid_next;
			sp_data_reg <= sp_data_next;
			id_reg <= ID_CODE;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign RD_VALID_O = rd_valid_reg;
	assign RD_BIT_O = rd_bit_reg;
	assign SP_RD_VALID_O = sp_valid_reg;
	assign SP_RD_DATA_O = sp_data_reg;
	assign NV_WR_O = nv_wr_reg;
	assign NV_WR_DATA_O = nv_data_reg;
	assign EXT_POWERED_O = ext_pwr_reg;
	assign CONV_BUSY_O = (state_reg == ST_CONV);
	assign ALARM_O = alarm_reg;
	assign TEMP_RESULT_O = temp_reg;
	assign ID_CODE_O = id_reg;
endmodule : tcr_top
`default_nettype wire

/* File: inc/tcr_pkg.sv */
// Behaviour
// - Resolution 9, 10, 11 or 12 bits, chosen by the configuration byte.
// - Resolution is 12 bits after power-up unless a stored configuration loads.
// - Idle after reset; a conversion starts only on command code 44h.
// - At conversion end the result register is written, then back to idle.
// - Read slots answer 0 while converting and 1 once done.
// - Result is 16-bit sign-extended two's complement, bits 15..11 sign.
// - Sign bits all 0 for positive and all 1 for negative results.
// - Below 12 bits the low result bits carry no data.
// - Result register resets to 0550h, plus 85 degrees.
// - A 12-bit conversion completes within 750 ms of the start command.
// - Alarm limits and configuration are kept in nonvolatile storage.
// - Scratchpad gives access to both alarm limits and the configuration byte.
// - Temperature is reported in Celsius only.
// - Each device holds a unique 64-bit identification code.
// - After each conversion bits 11..4 are compared with both alarm limits.
// - Result low byte is scratchpad byte 0, high byte byte 1, read-only.
package tcr_pkg;
	// ****************************************
	// Commands and scratchpad map
	// ****************************************
	localparam logic [7:0] CMD_CONVERT = 8'h44;
	localparam logic [3:0] SP_TEMP_LO = 4'h0;
	localparam logic [3:0] SP_TEMP_HI = 4'h1;
	localparam logic [3:0] SP_ALARM_HI = 4'h2;
	localparam logic [3:0] SP_ALARM_LO = 4'h3;
	localparam logic [3:0] SP_CONFIG = 4'h4;
	localparam logic [3:0] SP_RSVD_FIRST = 4'h5;
	localparam logic [3:0] SP_RSVD_LAST = 4'h7;
	localparam logic [3:0] SP_CHECK = 4'h8;
	localparam logic [7:0] SP_RSVD_VALUE = 8'hff;
	localparam logic [7:0] SP_CHECK_VALUE = 8'h00;
	localparam logic [7:0] SP_UNMAPPED_VALUE = 8'h00;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int CFG_RES_LSB = 5;
	localparam logic [1:0] RES_9 = 2'h0;
	localparam logic [1:0] RES_12 = 2'h3;
	localparam logic [15:0] TEMP_RESET = 16'h0550;
	localparam logic [7:0] CONFIG_RESET = 8'h7f;
	localparam logic [7:0] ALARM_HI_RESET = 8'h7f;
	localparam logic [7:0] ALARM_LO_RESET = 8'h80;
	localparam int SIGN_BIT = 11;
	localparam int CMP_LSB = 4;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_KHZ = 50000;
	localparam int CONV_TIME_MS = 750;
	localparam int CONV_CYCLES_12 = CONV_TIME_MS * CLK_KHZ;
	localparam int CNT_W = 26;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [7:0] alarm_hi;
		logic [7:0] alarm_lo;
		logic [7:0] config_byte;
	} tcr_nv_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
	} tcr_sp_wr_t;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_CONV
	} tcr_state_t;
endpackage : tcr_pkg

/* File: tb/tcr_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module tcr_chk #(parameter int CONV_CYCLES = 64) (
	input wire logic CLK_I, ARST_N_I, CMD_VALID_I, RD_SLOT_I, SP_RD_I,
	input wire logic [7:0] CMD_CODE_I,
	input wire logic RD_VALID_O, RD_BIT_O, SP_RD_VALID_O, CONV_BUSY_O, ALARM_O,
	input wire logic [15:0] TEMP_RESULT_O
);
	logic [31:0] cnt_reg;
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= CONV_BUSY_O ? cnt_reg + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);
	start_busy_a: assert property (CMD_VALID_I && CMD_CODE_I == 8'h44 && !CONV_BUSY_O |=> CONV_BUSY_O)
		else $error("conversion did not start");
	idle_hold_a: assert property (!CONV_BUSY_O && !(CMD_VALID_I && CMD_CODE_I == 8'h44) |=> !CONV_BUSY_O)
		else $error("conversion started without command");
	slot_answer_a: assert property (RD_SLOT_I |=> RD_VALID_O && RD_BIT_O == !$past(CONV_BUSY_O))
		else $error("wrong read slot answer");
	sign_bits_a: assert property (TEMP_RESULT_O[15:12] == {4{TEMP_RESULT_O[11]}})
		else $error("sign bits differ");
	result_update_a: assert property ($changed(TEMP_RESULT_O) |-> $fell(CONV_BUSY_O))
		else $error("result changed outside completion");
	alarm_update_a: assert property ($changed(ALARM_O) |-> $fell(CONV_BUSY_O))
		else $error("alarm changed outside completion");
	sp_answer_a: assert property (SP_RD_I |=> SP_RD_VALID_O)
		else $error("scratchpad read not answered");
	conv_bound_a: assert property ($rose(CONV_BUSY_O) |-> ##[1:1000] !CONV_BUSY_O)
		else $error("conversion too long");
	busy_len_a: assert property ($fell(CONV_BUSY_O) |-> cnt_reg <= CONV_CYCLES && cnt_reg >= CONV_CYCLES / 8)
		else $error("conversion length out of range");
endmodule : tcr_chk
bind tcr_top tcr_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
	.CMD_VALID_I(CMD_VALID_I), .RD_SLOT_I(RD_SLOT_I), .SP_RD_I(SP_RD_I), .CMD_CODE_I(CMD_CODE_I),
	.RD_VALID_O(RD_VALID_O), .RD_BIT_O(RD_BIT_O), .SP_RD_VALID_O(SP_RD_VALID_O),
	.CONV_BUSY_O(CONV_BUSY_O), .ALARM_O(ALARM_O), .TEMP_RESULT_O(TEMP_RESULT_O));
`default_nettype wire

/* File: tb/tcr_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tcr_master_model (
	input wire logic clk_i, rst_ni, go_i, ext_pow_i, rd_valid_i, rd_bit_i,
	input wire logic [7:0] code_i,
	output logic cmd_valid_o, rd_slot_o, done_o,
	output logic [7:0] cmd_code_o
);
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			cmd_valid_o <= 1'b0;
			cmd_code_o <= 8'h00;
			rd_slot_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			cmd_valid_o <= go_i;
			// Code lines toggle when idle so stale values never look valid
			cmd_code_o <= go_i ? code_i : ~cmd_code_o;
			if (cmd_valid_o && cmd_code_o == 8'h44) begin
				rd_slot_o <= ext_pow_i;
			end else if (rd_valid_i && rd_bit_i) begin
				rd_slot_o <= 1'b0;
			end
			done_o <= rd_slot_o && rd_valid_i && rd_bit_i;
		end
	end
endmodule : tcr_master_model
`default_nettype wire

/* File: tb/tcr_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tcr_top_tb;
	import tcr_pkg::*;
	localparam int CC = 64;
	localparam logic [63:0] ID = 64'h5a3c_0f1e_7788_9902; // Arbitrary value
	logic clk = 0, rst_n = 0, go = 0, sp_rd = 0, sp_wr = 0, nv_st = 0, sup = 1, nv_v = 0;
	tcr_nv_t nv_i = '0;
	logic [63:0] id;
	logic [7:0] code = 8'h00;
	logic [3:0] sp_a = 4'h0;
	tcr_sp_wr_t wd = '0;
	logic [11:0] sense = 12'h000;
	logic cmd_v, rd_slot, rd_v, rd_b, sp_v, nv_wr, busy, alarm, done, ext;
	logic [7:0] cmd_c, sp_d, d;
	tcr_nv_t nv_d;
	logic [15:0] temp;
	logic [31:0] seed = 32'h3b0e;
	int n_errors = 0, comparisons = 0;
	always #10 clk = ~clk;
	tcr_top #(.CONV_CYCLES(CC), .ID_CODE(ID)) dut (.CLK_I(clk), .ARST_N_I(rst_n), .CMD_VALID_I(cmd_v),
		.CMD_CODE_I(cmd_c),
		.RD_SLOT_I(rd_slot), .RD_VALID_O(rd_v), .RD_BIT_O(rd_b), .SP_RD_I(sp_rd), .SP_RD_ADDR_I(sp_a),
		.SP_RD_VALID_O(sp_v), .SP_RD_DATA_O(sp_d), .SP_WR_I(sp_wr), .SP_WR_DATA_I(wd), .NV_VALID_I(nv_v),
		.NV_IMAGE_I(nv_i), .NV_STORE_I(nv_st), .NV_WR_O(nv_wr), .NV_WR_DATA_O(nv_d), .SENSE_I(sense),
		.SUPPLY_PIN_I(sup), .EXT_POWERED_O(ext), .CONV_BUSY_O(busy), .ALARM_O(alarm),
		.TEMP_RESULT_O(temp), .ID_CODE_O(id));
	tcr_master_model pm (.clk_i(clk), .rst_ni(rst_n), .go_i(go), .ext_pow_i(ext), .rd_valid_i(rd_v),
		.rd_bit_i(rd_b), .code_i(code), .cmd_valid_o(cmd_v), .rd_slot_o(rd_slot), .done_o(done),
		.cmd_code_o(cmd_c));
	function logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task spr(input logic [3:0] a);
		@(posedge clk) begin sp_rd <= 1; sp_a <= a; end
		@(posedge clk) sp_rd <= 0;
		#1 chk(sp_v, 1);
		d = sp_d;
	endtask : spr
	task spw(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk) begin sp_wr <= 1; wd <= {a, v}; end
		@(posedge clk) sp_wr <= 0;
	endtask : spw
	task conv(input logic [1:0] res, input logic [11:0] s);
		int n;
		logic [11:0] m;
		logic [15:0] e;
		spw(SP_CONFIG, {1'b0, res, 5'h1f});
		@(posedge clk) begin sense <= s; go <= 1; code <= CMD_CONVERT; end
		@(posedge clk) go <= 0;
		n = 0;
		// Bounded wait: a lost completion ends the loop instead of hanging
		repeat (2000) begin
			@(posedge clk);
			#1 if (busy === 1'b1) n++;
			if (done === 1'b1) break;
		end
		m = s & ~((12'h1 << (3 - res)) - 12'h1);
		e = {{4{m[11]}}, m};
		chk(n, CC >> (3 - res));
		chk(temp, e);
		chk(alarm, $signed(e[11:4]) > $signed(8'h10) || $signed(e[11:4]) < $signed(8'hf0));
		spr(SP_TEMP_LO);
		chk(d, e[7:0]);
		spr(SP_TEMP_HI);
		chk(d, e[15:8]);
		$display("test conversion res %0d done", res);
	endtask : conv
	task stop_test;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		#1 chk(temp, 16'h0550);
		chk(busy, 0);
		chk(ext, 0);
		@(posedge clk) rst_n <= 1;
		spr(SP_CONFIG);
		chk(d, 8'h7f);
		spr(SP_TEMP_HI);
		chk(d, 8'h05);
		chk(ext, 1);
		chk(id[31:0], ID[31:0]);
		chk(id[63:32], ID[63:32]);
		spw(SP_TEMP_LO, 8'haa);
		spr(SP_TEMP_LO);
		chk(d, 8'h50);
		spw(SP_ALARM_HI, 8'h10);
		spw(SP_ALARM_LO, 8'hf0);
		spr(SP_ALARM_LO);
		chk(d, 8'hf0);
		seed = xs(seed);
		@(posedge clk) begin go <= 1; code <= (seed[7:0] == 8'h44) ? 8'h4e : seed[7:0]; end
		@(posedge clk) go <= 0;
		repeat (4) @(posedge clk);
		#1 chk(busy, 0);
		$display("test setup done");
		conv(2'h3, 12'h7d0);
		conv(2'h3, 12'hc90);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			conv(i[1:0], seed[11:0]);
		end
		@(posedge clk) nv_st <= 1;
		@(posedge clk) nv_st <= 0;
		#1 chk(nv_wr, 1);
		chk(nv_d, {8'h10, 8'hf0, 8'h7f});
		@(posedge clk) begin go <= 1; code <= CMD_CONVERT; end
		@(posedge clk) go <= 0;
		repeat (5) @(posedge clk);
		rst_n <= 0;
		nv_v <= 1;
		nv_i <= {8'h20, 8'he0, 8'h3f};
		#1 chk(temp, 16'h0550);
		chk(busy, 0);
		// Second release loads the stored image in its first edge
		@(posedge clk) rst_n <= 1;
		spr(SP_CONFIG);
		chk(d, 8'h3f);
		spr(SP_ALARM_HI);
		chk(d, 8'h20);
		$display("test store and reset done");
		stop_test;
	end
	// Whole run needs about 500 cycles; allow sixty times that
	initial begin
		#600000;
		n_errors++;
		stop_test;
	end
endmodule : tcr_top_tb
`default_nettype wire
